/* File: hw/dedicated_io_cfg.svh */
// Offsets, field positions, reset values and widths for the dedicated I/O handshake block.
`ifndef DEDICATED_IO_CFG_SVH
`define DEDICATED_IO_CFG_SVH

// =====================================================================
// Register byte addresses.
`define DIO_ADDR_W          8
`define DIO_OFS_CTRL        8'h00
`define DIO_OFS_STATUS      8'h04
`define DIO_OFS_FIELD_CFG   8'h08
`define DIO_OFS_LINE        8'h0C
`define DIO_OFS_PROGRAM     8'h10
`define DIO_OFS_OVERRIDE    8'h14
`define DIO_OFS_SLOT_DONE   8'h18
`define DIO_OFS_GP_OUT      8'h1C

// =====================================================================
// Control register bits, write one to act.
`define DIO_CTRL_EVASION_DONE 0
`define DIO_CTRL_EMG_CLEAR    1

// =====================================================================
// Numeric field configuration byte positions and reset values.
`define DIO_CFG_IN_START_LSB  0
`define DIO_CFG_IN_END_LSB    8
`define DIO_CFG_OUT_START_LSB 16
`define DIO_CFG_OUT_END_LSB   24
`define DIO_RST_IN_START      8'h00
`define DIO_RST_IN_END        8'h0F
`define DIO_RST_OUT_START     8'h00
`define DIO_RST_OUT_END       8'h0F

// =====================================================================
// Widths.
`define DIO_SLOTS           32
`define DIO_NUM_W           32
`define DIO_GP_W            32

`endif

/* File: hw/dedicated_io_pkg.sv */
// Types shared by the dedicated I/O handshake block.
package dedicated_io_pkg;

  // Single-bit dedicated inputs, carried together through the synchroniser.
  typedef struct packed {
    logic servo_off_enable;
    logic servo_on_request;
    logic operation_rights_request;
    logic machine_lock_toggle;
    logic evasion_return_request;
    logic general_output_clear;
    logic emergency_stop_in;
    logic program_select;
    logic override_select;
    logic program_number_output_request;
    logic line_number_output_request;
    logic override_value_output_request;
  } pin_in_type;

  // Single-bit dedicated status outputs.
  typedef struct packed {
    logic servo_enable_echo;
    logic servo_active;
    logic operation_rights_granted;
    logic machine_lock_active;
    logic evasion_return_busy;
    logic emergency_stop_status;
    logic program_output_active;
    logic line_output_active;
    logic override_output_active;
  } pin_out_type;

  // Which value is shown on the numeric output field.
  typedef enum logic [1:0] {
    SHOW_NONE,
    SHOW_PROGRAM,
    SHOW_LINE,
    SHOW_OVERRIDE
  } show_type;

endpackage

/* File: hw/dedicated_io_handshake.sv */
// Dedicated discrete input/output handshake logic with a plain register port.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dedicated_io_cfg.svh"

// Function
// R1: Servo off held while servo-off enable active.
// R2: Echo servo-on disable condition on output.
// R3: Servo-on request rising edge turns servo on.
// R4: Servo-active output follows servo on state.
// R5: Partner holds rights request as level.
// R6: Rights granted output while rights valid.
// R7: Machine-lock rising edge toggles lock state.
// R8: Machine-lock state shown on status output.
// R9: Evasion edge starts return, busy shown.
// R10: Output-clear edge resets general outputs.
// R11: Emergency stop status after stop occurs.
// R12: Per-slot start edge runs that slot.
// R13: Per-slot halt level holds slot waiting.
// R14: Program select edge latches numeric input.
// R15: Override select edge latches numeric input.
// R16: Partner drives numeric input field as level.
// R17: Device drives configured numeric output field.
// R18: Program output request shows program number.
// R19: Line output request shows line number.
// R20: Override output request shows override value.
// R21: Level inputs act only while on.
// R22: Edge inputs act on rise, state kept.
// R23: Field set by in/out start, end numbers.
// R24: Unsigned fields, LSB at start, edge-cycle sample.
module dedicated_io_handshake #(
  parameter int SLOTS = `DIO_SLOTS,
  parameter int NUM_W = `DIO_NUM_W,
  parameter int GP_W  = `DIO_GP_W
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire dedicated_io_pkg::pin_in_type pins_in,
  input  wire logic [SLOTS-1:0]            slot_start,
  input  wire logic [SLOTS-1:0]            slot_halt,
  input  wire logic [NUM_W-1:0]            numeric_value_in,
  output var  dedicated_io_pkg::pin_out_type pins_out,
  output var  logic [SLOTS-1:0]            slot_running,
  output var  logic [SLOTS-1:0]            slot_waiting,
  output var  logic [NUM_W-1:0]            numeric_value_out,
  output var  logic [GP_W-1:0]             general_outputs,
  input  wire logic [`DIO_ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output var  logic [31:0]                 reg_rdata
);
  import dedicated_io_pkg::*;

  // =====================================================================
  // Field helpers.

  // Pulls the bits start..end of a pin field down to an unsigned value.
  function automatic logic [NUM_W-1:0] field_take(input logic [NUM_W-1:0] v,
                                                  input logic [7:0] s, input logic [7:0] e);
    logic [NUM_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_W; i++) begin
      if (i >= int'(s) && i <= int'(e)) begin
        r[i-int'(s)] = v[i];
      end
    end
    return r;
  endfunction

  // Places an unsigned value on bits start..end; bits outside read zero.
  function automatic logic [NUM_W-1:0] field_place(input logic [NUM_W-1:0] v,
                                                   input logic [7:0] s, input logic [7:0] e);
    logic [NUM_W-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_W; i++) begin
      if (i >= int'(s) && i <= int'(e)) begin
        r[i] = v[i-int'(s)];
      end
    end
    return r;
  endfunction

  // =====================================================================
  // Input synchronisers and edge detection.

  pin_in_type       pin_meta;
  pin_in_type       lv;
  pin_in_type       lv_prev;
  pin_in_type       rise;
  logic [SLOTS-1:0] start_meta;
  logic [SLOTS-1:0] start_lv;
  logic [SLOTS-1:0] start_prev;
  logic [SLOTS-1:0] start_rise;
  logic [SLOTS-1:0] halt_meta;
  logic [SLOTS-1:0] halt_lv;
  logic [NUM_W-1:0] num_meta;
  logic [NUM_W-1:0] num_lv;

  // Every pin passes two flops; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta   <= '0;
      lv         <= '0;
      lv_prev    <= '0;
      start_meta <= '0;
      start_lv   <= '0;
      start_prev <= '0;
      halt_meta  <= '0;
      halt_lv    <= '0;
      num_meta   <= '0;
      num_lv     <= '0;
    end else begin
      pin_meta   <= pins_in;
      lv         <= pin_meta;
      lv_prev    <= lv;
      start_meta <= slot_start;
      start_lv   <= start_meta;
      start_prev <= start_lv;
      halt_meta  <= slot_halt;
      halt_lv    <= halt_meta;
      num_meta   <= numeric_value_in;
      num_lv     <= num_meta;
    end
  end

  // Edge-type inputs act on the off-to-on change only. R22
  assign rise       = lv & ~lv_prev;
  assign start_rise = start_lv & ~start_prev;

  // =====================================================================
  // Register port decode.

  logic        wr_ctrl;
  logic        wr_cfg;
  logic        wr_line;
  logic        wr_done;
  logic        wr_gp;
  logic [31:0] field_cfg;
  logic [7:0]  in_start;
  logic [7:0]  in_end;
  logic [7:0]  out_start;
  logic [7:0]  out_end;
  logic [NUM_W-1:0] line_number;
  logic [NUM_W-1:0] program_number;
  logic [NUM_W-1:0] override_value;

  assign wr_ctrl = reg_write && (reg_addr == `DIO_OFS_CTRL);
  assign wr_cfg  = reg_write && (reg_addr == `DIO_OFS_FIELD_CFG);
  assign wr_line = reg_write && (reg_addr == `DIO_OFS_LINE);
  assign wr_done = reg_write && (reg_addr == `DIO_OFS_SLOT_DONE);
  assign wr_gp   = reg_write && (reg_addr == `DIO_OFS_GP_OUT);

  // The four range numbers, in order in start, in end, out start, out end. R23
  assign in_start  = field_cfg[`DIO_CFG_IN_START_LSB +: 8];
  assign in_end    = field_cfg[`DIO_CFG_IN_END_LSB +: 8];
  assign out_start = field_cfg[`DIO_CFG_OUT_START_LSB +: 8];
  assign out_end   = field_cfg[`DIO_CFG_OUT_END_LSB +: 8];

  // Field configuration and the line number that the program runner reports.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      field_cfg   <= {`DIO_RST_OUT_END, `DIO_RST_OUT_START, `DIO_RST_IN_END, `DIO_RST_IN_START};
      line_number <= '0;
    end else begin
      if (wr_cfg) begin
        field_cfg <= reg_wdata;
      end
      if (wr_line) begin
        line_number <= reg_wdata[NUM_W-1:0];
      end
    end
  end

  // =====================================================================
  // Servo, operation rights and machine lock.

  logic servo_on_state;
  logic rights_valid;
  logic machine_lock;

  // Servo-off enable dominates a simultaneous servo-on edge. R1 R3
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      servo_on_state <= 1'b0;
    end else if (lv.servo_off_enable) begin
      servo_on_state <= 1'b0; // R1 R21
    end else if (rise.servo_on_request) begin
      servo_on_state <= 1'b1; // R3
    end
  end

  // Rights last exactly as long as the partner holds its request. R6 R21
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rights_valid <= 1'b0;
    end else begin
      rights_valid <= lv.operation_rights_request; // R6
    end
  end

  // Each rising edge flips the lock shared by all mechanisms. R7
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      machine_lock <= 1'b0;
    end else if (rise.machine_lock_toggle) begin
      machine_lock <= ~machine_lock; // R7
    end
  end

  // =====================================================================
  // Evasion return, emergency stop and general outputs.

  logic evasion_busy;
  logic emg_flag;

  // Return runs until software reports arrival; a new edge wins over the done write. R9
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evasion_busy <= 1'b0;
    end else if (rise.evasion_return_request) begin
      evasion_busy <= 1'b1; // R9
    end else if (wr_ctrl && reg_wdata[`DIO_CTRL_EVASION_DONE]) begin
      evasion_busy <= 1'b0;
    end
  end

  // Sticky stop flag; a stop in the clearing cycle is kept. R11
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      emg_flag <= 1'b0;
    end else if (lv.emergency_stop_in) begin
      emg_flag <= 1'b1; // R11
    end else if (wr_ctrl && reg_wdata[`DIO_CTRL_EMG_CLEAR]) begin
      emg_flag <= 1'b0;
    end
  end

  // The clear edge beats a software write in the same cycle. R10
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      general_outputs <= '0;
    end else if (rise.general_output_clear) begin
      general_outputs <= '0; // R10
    end else if (wr_gp) begin
      general_outputs <= reg_wdata[GP_W-1:0];
    end
  end

  // =====================================================================
  // Per-slot start and halt.

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      // A start edge wins over a finish report from software. R12 R22
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          slot_running[g] <= 1'b0;
        end else if (start_rise[g]) begin
          slot_running[g] <= 1'b1; // R12
        end else if (wr_done && reg_wdata[g]) begin
          slot_running[g] <= 1'b0;
        end
      end

      // A running slot waits only while its halt input stays on. R13 R21
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          slot_waiting[g] <= 1'b0;
        end else begin
          slot_waiting[g] <= halt_lv[g] && (slot_running[g] || start_rise[g]); // R13
        end
      end
    end
  endgenerate

  // =====================================================================
  // Program and override selection from the numeric input field.

  // The value is taken in the cycle where the edge is seen. R14 R24
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      program_number <= '0;
    end else if (rise.program_select) begin
      program_number <= field_take(num_lv, in_start, in_end); // R14
    end
  end

  // Same sampling as program selection. R15 R24
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      override_value <= '0;
    end else if (rise.override_select) begin
      override_value <= field_take(num_lv, in_start, in_end); // R15
    end
  end

  // =====================================================================
  // Numeric output selection.

  show_type         show;
  show_type         next_show;
  logic [NUM_W-1:0] show_value;

  // Latest request wins; program, line, override on a tie.
  always_comb begin
    next_show = show;
    if (rise.program_number_output_request) begin
      next_show = SHOW_PROGRAM; // R18
    end else if (rise.line_number_output_request) begin
      next_show = SHOW_LINE; // R19
    end else if (rise.override_value_output_request) begin
      next_show = SHOW_OVERRIDE; // R20
    end
  end

  always_comb begin
    case (next_show)
      SHOW_PROGRAM:  show_value = program_number;
      SHOW_LINE:     show_value = line_number;
      SHOW_OVERRIDE: show_value = override_value;
      default:       show_value = '0;
    endcase
  end

  // The field tracks the chosen value, so a later change still shows. R17
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      show              <= SHOW_NONE;
      numeric_value_out <= '0;
    end else begin
      show              <= next_show;
      numeric_value_out <= field_place(show_value, out_start, out_end); // R17 R24
    end
  end

  // =====================================================================
  // Status outputs.

  always_comb begin
    pins_out.servo_enable_echo        = lv_prev.servo_off_enable; // R2
    pins_out.servo_active             = servo_on_state; // R4
    pins_out.operation_rights_granted = rights_valid;
    pins_out.machine_lock_active      = machine_lock; // R8
    pins_out.evasion_return_busy      = evasion_busy;
    pins_out.emergency_stop_status    = emg_flag;
    pins_out.program_output_active    = (show == SHOW_PROGRAM);
    pins_out.line_output_active       = (show == SHOW_LINE);
    pins_out.override_output_active   = (show == SHOW_OVERRIDE);
  end

  // =====================================================================
  // Read port; unmapped addresses read zero.

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        `DIO_OFS_STATUS:    next_rdata = 32'(pins_out);
        `DIO_OFS_FIELD_CFG: next_rdata = field_cfg;
        `DIO_OFS_LINE:      next_rdata = 32'(line_number);
        `DIO_OFS_PROGRAM:   next_rdata = 32'(program_number);
        `DIO_OFS_OVERRIDE:  next_rdata = 32'(override_value);
        `DIO_OFS_SLOT_DONE: next_rdata = 32'(slot_running);
        `DIO_OFS_GP_OUT:    next_rdata = 32'(general_outputs);
        default:            next_rdata = '0;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // =====================================================================
  // Checks.

  property p_servo_off;
    @(posedge clk) disable iff (!rst_b) lv.servo_off_enable |=> !pins_out.servo_active;
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("servo on while off enable held"); // R1

  property p_servo_on;
    @(posedge clk) disable iff (!rst_b)
      (rise.servo_on_request && !lv.servo_off_enable) |=> pins_out.servo_active;
  endproperty
  a_servo_on: assert property (p_servo_on) else $error("servo did not turn on"); // R3

  property p_lock_toggle;
    @(posedge clk) disable iff (!rst_b)
      rise.machine_lock_toggle |=> (machine_lock != $past(machine_lock));
  endproperty
  a_lock_toggle: assert property (p_lock_toggle) else $error("machine lock did not flip"); // R7

  property p_evasion;
    @(posedge clk) disable iff (!rst_b)
      rise.evasion_return_request |=> pins_out.evasion_return_busy;
  endproperty
  a_evasion: assert property (p_evasion) else $error("evasion return not busy"); // R9

  property p_gp_clear;
    @(posedge clk) disable iff (!rst_b) rise.general_output_clear |=> (general_outputs == '0);
  endproperty
  a_gp_clear: assert property (p_gp_clear) else $error("general outputs not cleared"); // R10

  property p_emg;
    @(posedge clk) disable iff (!rst_b) lv.emergency_stop_in |=> pins_out.emergency_stop_status;
  endproperty
  a_emg: assert property (p_emg) else $error("emergency stop status missing"); // R11

  property p_slot_start;
    @(posedge clk) disable iff (!rst_b)
      (start_rise != '0) |=> ((slot_running & $past(start_rise)) == $past(start_rise));
  endproperty
  a_slot_start: assert property (p_slot_start) else $error("started slot not running"); // R12

  property p_slot_wait;
    @(posedge clk) disable iff (!rst_b) ##1 ((slot_waiting & ~$past(halt_lv)) == '0);
  endproperty
  a_slot_wait: assert property (p_slot_wait) else $error("slot waits without halt"); // R13

  property p_prog_sel;
    @(posedge clk) disable iff (!rst_b)
      rise.program_select |=> (program_number == field_take($past(num_lv), $past(in_start),
                                                            $past(in_end)));
  endproperty
  a_prog_sel: assert property (p_prog_sel) else $error("program number not latched"); // R14

  property p_prog_out;
    @(posedge clk) disable iff (!rst_b)
      rise.program_number_output_request |=> pins_out.program_output_active
        && !pins_out.line_output_active;
  endproperty
  a_prog_out: assert property (p_prog_out) else $error("program output not shown"); // R18

endmodule
`default_nettype wire

/* File: bench/dio_plc_model.sv */
// Sequencer model that drives the dedicated inputs of the handshake block.
`timescale 1ns/1ps
`default_nettype none
module dio_plc_model (
  input  wire logic                         clk,
  output var  dedicated_io_pkg::pin_in_type pins_in,
  output var  logic [31:0]                  slot_start,
  output var  logic [31:0]                  slot_halt,
  output var  logic [31:0]                  numeric_value_in
);
  import dedicated_io_pkg::*;

  // ====================================================================
  // Lines start low, so the block sees no edge while it leaves reset.
  initial begin
    pins_in = '0;
    slot_start = '0;
    slot_halt = '0;
    numeric_value_in = '0;
  end

  // ====================================================================
  // Each change is held five edges, beyond the three-flop capture depth.
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  // Level control; the rights request stays up for as long as control is wanted.
  task automatic level(input pin_in_type m, input logic on);
    @(posedge clk);
    pins_in <= on ? (pins_in | m) : (pins_in & ~m);
    settle();
  endtask

  // An edge request is a clean off-on-off pulse, so the block acts once.
  task automatic pulse(input pin_in_type m);
    level(m, 1'b1);
    level(m, 1'b0);
  endtask

  // The value stands before and after a select edge, so it is sampled steady.
  task automatic present(input logic [31:0] v);
    @(posedge clk);
    numeric_value_in <= v;
    settle();
  endtask

  // One slot line, start or halt, set to the given level.
  task automatic slot_line(input logic is_halt, input int n, input logic on);
    @(posedge clk);
    if (is_halt) begin
      slot_halt[n] <= on;
    end else begin
      slot_start[n] <= on;
    end
    settle();
  endtask
endmodule
`default_nettype wire

/* File: bench/dedicated_io_handshake_tb_top.sv */
// Self-checking bench for the dedicated I/O handshake block.
`timescale 1ns/1ps
`default_nettype none
`include "dedicated_io_cfg.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module dedicated_io_handshake_tb_top;
  import dedicated_io_pkg::*;
  typedef struct packed {logic [1:0] op; logic [11:0] mask; logic [8:0] exp;} row_type;
  logic        clk;
  logic        rst_b;
  pin_in_type  pins_in;
  pin_out_type pins_out;
  logic [31:0] slot_start;
  logic [31:0] slot_halt;
  logic [31:0] numeric_value_in;
  logic [31:0] slot_running;
  logic [31:0] slot_waiting;
  logic [31:0] numeric_value_out;
  logic [31:0] general_outputs;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [31:0] reg_rdata;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          checked = 0;
  // Op 0 pulses the lines, 1 raises them, 2 drops them; exp is the whole status word.
  row_type     rows [12] = '{
    {2'h0, 12'h400, 9'h080}, {2'h1, 12'h800, 9'h100}, {2'h0, 12'h400, 9'h100},
    {2'h2, 12'h800, 9'h000}, {2'h0, 12'h400, 9'h080}, {2'h1, 12'h200, 9'h0C0},
    {2'h2, 12'h200, 9'h080}, {2'h0, 12'h100, 9'h0A0}, {2'h0, 12'h100, 9'h080},
    {2'h0, 12'h080, 9'h090}, {2'h1, 12'h020, 9'h098}, {2'h2, 12'h020, 9'h098}};
  // The last request is two at once, where the program number must win.
  logic [11:0] outreq [4] = '{12'h004, 12'h002, 12'h001, 12'h006};
  logic [2:0]  outind [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
  logic [31:0] outval [4] = '{32'h0000A500, 32'h00005A00, 32'h00003700, 32'h0000A500};

  // ====================================================================
  dedicated_io_handshake i_dut (
    .clk(clk), .rst_b(rst_b), .pins_in(pins_in), .slot_start(slot_start),
    .slot_halt(slot_halt), .numeric_value_in(numeric_value_in), .pins_out(pins_out),
    .slot_running(slot_running), .slot_waiting(slot_waiting),
    .numeric_value_out(numeric_value_out), .general_outputs(general_outputs),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  dio_plc_model i_plc (
    .clk(clk), .pins_in(pins_in), .slot_start(slot_start), .slot_halt(slot_halt),
    .numeric_value_in(numeric_value_in));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ====================================================================
  // One-cycle write strobe; the write lands at the edge that ends the task.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Verdict and end of run, shared by the main sequence and the watchdog.
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  // ====================================================================
  // Reset, the row table, then the awkward cases by hand.
  initial begin
    rst_b = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (10) @(posedge clk);
    `CHK("pins_out in reset", 9'h000, pins_out)
    rst_b <= 1'b1;
    reg_rd(`DIO_OFS_FIELD_CFG, rd);
    `CHK("field cfg reset", ({`DIO_RST_OUT_END, `DIO_RST_OUT_START, `DIO_RST_IN_END, `DIO_RST_IN_START}), rd)
    reg_rd(8'h40, rd);
    `CHK("unmapped read", 32'h00000000, rd)
    for (int i = 0; i < 12; i++) begin
      if (rows[i].op == 2'h0)
        i_plc.pulse(rows[i].mask);
      else
        i_plc.level(rows[i].mask, rows[i].op == 2'h1);
      `CHK("pins_out row", rows[i].exp, pins_out)
    end
    reg_rd(`DIO_OFS_STATUS, rd);
    `CHK("status word", 32'h00000098, rd)
    reg_wr(`DIO_OFS_CTRL, 32'h1 << `DIO_CTRL_EVASION_DONE);
    `CHK("return ended", 9'h088, pins_out)
    reg_wr(`DIO_OFS_CTRL, 32'h1 << `DIO_CTRL_EMG_CLEAR);
    `CHK("stop cleared", 9'h080, pins_out)
    // Input field 4..11 and output field 8..15; stray ones lie outside the input field.
    reg_wr(`DIO_OFS_FIELD_CFG, 32'h0F080B04);
    i_plc.present(32'hFFFFFA5F);
    i_plc.pulse(12'h010);
    reg_rd(`DIO_OFS_PROGRAM, rd);
    `CHK("program number", 32'h000000A5, rd)
    i_plc.present(32'h0000037F);
    i_plc.pulse(12'h008);
    reg_rd(`DIO_OFS_OVERRIDE, rd);
    `CHK("override value", 32'h00000037, rd)
    reg_wr(`DIO_OFS_LINE, 32'h0000005A);
    for (int i = 0; i < 4; i++) begin
      i_plc.pulse(outreq[i]);
      `CHK("indicators", outind[i], pins_out[2:0])
      `CHK("numeric out", outval[i], numeric_value_out)
    end
    reg_wr(`DIO_OFS_GP_OUT, 32'hDEADBEEF);
    `CHK("general outputs", 32'hDEADBEEF, general_outputs)
    i_plc.pulse(12'h040);
    `CHK("outputs cleared", 32'h00000000, general_outputs)
    // First and last slot start; only those two run.
    i_plc.slot_line(1'b0, 0, 1'b1);
    i_plc.slot_line(1'b0, 0, 1'b0);
    i_plc.slot_line(1'b0, 31, 1'b1);
    i_plc.slot_line(1'b0, 31, 1'b0);
    `CHK("slots running", 32'h80000001, slot_running)
    i_plc.slot_line(1'b1, 31, 1'b1);
    `CHK("slot waiting", 32'h80000000, slot_waiting)
    i_plc.slot_line(1'b1, 31, 1'b0);
    `CHK("wait released", 32'h00000000, slot_waiting)
    reg_wr(`DIO_OFS_SLOT_DONE, 32'h00000001);
    reg_rd(`DIO_OFS_SLOT_DONE, rd);
    `CHK("slot done", 32'h80000000, rd)
    // A second reset in mid-run drops every state at once.
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    `CHK("pins_out mid reset", 9'h000, pins_out)
    `CHK("slots mid reset", 32'h00000000, slot_running)
    @(posedge clk);
    rst_b <= 1'b1;
    // After release the state stays at reset values and the port works again.
    @(posedge clk);
    #1;
    `CHK("pins_out after release", 9'h000, pins_out)
    reg_rd(`DIO_OFS_FIELD_CFG, rd);
    `CHK("field cfg after reset", ({`DIO_RST_OUT_END, `DIO_RST_OUT_START, `DIO_RST_IN_END, `DIO_RST_IN_START}), rd)
    // Read data stand one cycle only, then fall back to zero.
    @(posedge clk);
    #1;
    `CHK("read data drop", 32'h00000000, reg_rdata)
    reg_rd(`DIO_OFS_LINE, rd);
    `CHK("line after reset", 32'h00000000, rd)
    `CHK("numeric out after reset", 32'h00000000, numeric_value_out)
    final_report();
  end
endmodule
`default_nettype wire
